// ---- hdl/sidcr_pkg.sv ----
// Shared constants and carriers for the secure id and control register bank
package sidcr_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [15:0] OFF_ID1 = 16'h8004; // Stream id width word
  localparam logic [15:0] OFF_ID2 = 16'h8008; // Query page base word
  localparam logic [15:0] OFF_ID3 = 16'h800c; // Maintenance support word
  localparam logic [15:0] OFF_ID4 = 16'h8010; // Implementation word
  localparam logic [15:0] OFF_CTL = 16'h8020; // Secure control zero
  localparam logic [15:0] OFF_ACK = 16'h8024; // Secure control ack
  // ==========================================================
  // Field positions and widths
  localparam int SIDW_W      = 6;  // Stream id width field
  localparam int QBASE_W     = 10; // Query page base field
  localparam int MAINT_BIT   = 6;  // Maintenance restrict bit
  localparam int STALLD_BIT  = 9;  // Stall disable bit
  localparam int WILD_LSB    = 6;  // Wildcard field low bit
  localparam int WILD_W      = 3;  // Wildcard field width
  localparam int FETCH_BIT   = 5;  // Fetch guard bit
  // ==========================================================
  // Encodings and reset values
  localparam logic [1:0]  STALL_BOTH = 2'h0;       // Stall and terminate
  localparam logic [1:0]  STALL_TERM = 2'h1;       // Terminate only
  localparam logic [2:0]  WILD_EXACT = 3'h0;       // Exact match
  localparam logic [2:0]  WILD_MAX   = 3'h4;       // Widest wildcard
  localparam logic [31:0] CTL_RESET  = 32'h0000_0000;
  localparam logic [31:0] PAGE_OFF   = 32'h0002_0000; // Query page origin
  localparam logic [31:0] PAGE_STEP  = 32'h0001_0000; // Query page stride
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        valid;  // Access request
    logic        write;  // Write when set
    logic [15:0] addr;   // Byte offset
    logic [31:0] wdata;  // Write data
    logic        secure; // Secure attribute
    logic        root;   // Root attribute
  } sidcr_req_t;
  typedef struct packed {
    logic        valid;  // Answer strobe
    logic [31:0] rdata;  // Read data
  } sidcr_rsp_t;
  typedef struct packed {
    logic valid;      // Check request
    logic sec_stream; // Stream is secure
    logic instr;      // Fetch after attribute override
    logic s1_ns;      // Stage 1 output is non-secure
    logic s1_applied; // Stage 1 really translates
    logic ctx_a;      // Abort on terminate
    logic ctx_r;      // Record faults
    logic ctx_s;      // Stall faults
  } sidcr_fetch_t;
  typedef struct packed {
    logic valid;  // Result strobe
    logic fault;  // Permission fault raised
    logic abort;  // Terminated with abort
    logic stall;  // Transaction stalled
    logic event_; // Permission event logged
    logic cls_in; // Event class is input address
    logic s2;     // Stage 2 indicator
  } sidcr_fres_t;
endpackage : sidcr_pkg

// ---- hdl/sidcr_virtual_machine_tag_match.sv ----
// Virtual machine tag comparator for invalidation and lookup
`timescale 1ns/1ns
module sidcr_tag_match
  import sidcr_pkg::*;
#(
  parameter int TAG_W = 16 // Widest tag
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             wide_vm_tag_support_i,
  input  wire logic [2:0]       vm_tag_wildcard_i,
  input  wire logic             inv_valid_i,
  input  wire logic [TAG_W-1:0] inv_tag_i,
  input  wire logic             lkp_valid_i,
  input  wire logic [TAG_W-1:0] lkp_tag_i,
  input  wire logic [TAG_W-1:0] entry_tag_i,
  output logic                  inv_hit_o,
  output logic                  lkp_hit_o
);
  // ==========================================================
  // Compare masks
  logic [2:0]       ign;      // Low bits ignored
  logic [TAG_W-1:0] inv_mask; // Invalidation mask
  logic [TAG_W-1:0] lkp_mask; // Lookup mask
  logic             next_inv_hit;
  logic             next_lkp_hit;

  // Reserved wildcards behave as exact
  always_comb begin
    ign = (vm_tag_wildcard_i > WILD_MAX) ? WILD_EXACT : vm_tag_wildcard_i; // R12
  end

  // Per bit: upper eight bits set by tag width, low bits by wildcard
  genvar gi;
  generate
    for (gi = 0; gi < TAG_W; gi++) begin : g_mask
      assign lkp_mask[gi] = wide_vm_tag_support_i || (gi < 8); // R12
      assign inv_mask[gi] = lkp_mask[gi] && (gi >= ign);       // R11
    end
  endgenerate

  // Lookup never sees the wildcard
  always_comb begin
    next_inv_hit = inv_valid_i && (((inv_tag_i ^ entry_tag_i) & inv_mask) == '0); // R11
    next_lkp_hit = lkp_valid_i && (((lkp_tag_i ^ entry_tag_i) & lkp_mask) == '0); // R13
  end

  // Registered hits
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      inv_hit_o <= 1'b0;
      lkp_hit_o <= 1'b0;
    end else begin
      inv_hit_o <= next_inv_hit;
      lkp_hit_o <= next_lkp_hit;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_lookup_exact: assert property (lkp_valid_i && (lkp_tag_i != entry_tag_i) // R13
    && wide_vm_tag_support_i |=> !lkp_hit_o) else $error("lookup used wildcard");
  a_inv_reserved: assert property (inv_valid_i && vm_tag_wildcard_i > 3'h4 // R12
    && wide_vm_tag_support_i && inv_tag_i[0] != entry_tag_i[0] |=> !inv_hit_o)
    else $error("reserved wildcard not exact");
endmodule : sidcr_tag_match

// ---- hdl/sidcr_regs.sv ----
// Secure id words, secure control zero, its ack and the fetch guard check
//
// Contract
// [R1] Word one low field gives stream id width
// [R2] Id words: non-secure reads zero, writes ignored
// [R3] Absent secure state makes all read zero
// [R4] Word two gives query page base offset
// [R5] Query page only with secure, hyp, query
// [R6] Maintenance bit: one means secure queue rejects
// [R7] Word four holds full implementation value
// [R8] Stall disable forces non-secure terminate model
// [R9] Otherwise disable reserved, models mirror
// [R10] Reserved control bits never reach ack
// [R11] Wildcard ignores lowest one to four bits
// [R12] Reserved wildcard exact; top bit by width (code gates the upper eight bits by width)
// [R13] Wildcard never affects lookup matching
// [R14] Guard faults secure fetch to non-secure
// [R15] Unit disabled: abort, record no event
// [R16] Stage 1 skipped: abort, log if writable
// [R17] Stage 1 applied: descriptor decides stall
// [R18] Event carries input class, stage two zero
// [R19] Software invalidates caches after guard change
// [R20] Reset clears disable, guard and wildcard
// [R21] Control at 0x8020, gated, read write
// [R22] Ack reflects accepted control bits
// [R23] Gate evaluated on every single access
`timescale 1ns/1ns
module sidcr_regs
  import sidcr_pkg::*;
#(
  parameter bit          SECURE_PRESENT = 1'b1,         // Secure state built
  parameter bit          VA_QUERY       = 1'b1,         // Query pages built
  parameter bit          SECURE_HYP     = 1'b1,         // Secure hyp level
  parameter bit          ATS_PRESENT    = 1'b1,         // Device caches present
  parameter bit          MAINT_RESTRICT = 1'b0,         // Secure queue rejects
  parameter bit          WILD_SUPPORT   = 1'b1,         // Wildcard built
  parameter logic [5:0]  SID_WIDTH      = 6'h10,        // Stream id bits
  parameter logic [9:0]  QUERY_BASE     = 10'h001,      // Query page index
  parameter logic [31:0] IMPL_WORD      = 32'h0000_0000, // Arbitrary value
  parameter logic [1:0]  SEC_STALL      = 2'h0,         // Secure stall model
  parameter int          TAG_W          = 16            // Tag width
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire sidcr_req_t       req_i,
  output sidcr_rsp_t            rsp_o,
  input  wire logic             translation_unit_enable_i,
  input  wire logic             eventq_writable_i,
  input  wire sidcr_fetch_t     fetch_i,
  output sidcr_fres_t           fres_o,
  input  wire logic             wide_vm_tag_support_i,
  input  wire logic             inv_valid_i,
  input  wire logic [TAG_W-1:0] inv_tag_i,
  input  wire logic             lkp_valid_i,
  input  wire logic [TAG_W-1:0] lkp_tag_i,
  input  wire logic [TAG_W-1:0] entry_tag_i,
  output logic                  inv_hit_o,
  output logic                  lkp_hit_o,
  output logic [1:0]            ns_stall_model_o,
  output logic                  secure_query_page_o,
  output logic [31:0]           query_page_off_o
);
  // ==========================================================
  // Helpers
  // Address hit for one register
  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    return a == off;
  endfunction : hit

  // Secure or root access that may see the bank
  function automatic logic gate_ok(input sidcr_req_t r);
    return SECURE_PRESENT && (r.secure || r.root); // R3 R23
  endfunction : gate_ok

  // ==========================================================
  // Constant words and masks
  localparam bit STALLD_OK = (SEC_STALL == STALL_BOTH);  // Disable bit real
  localparam bit QPAGE     = SECURE_PRESENT && SECURE_HYP && VA_QUERY;
  localparam logic [31:0] ID1 = {26'h0, SID_WIDTH};                       // R1
  localparam logic [31:0] ID2 = VA_QUERY ? {22'h0, QUERY_BASE} : 32'h0;   // R4
  localparam logic [31:0] ID3 = {25'h0, ATS_PRESENT && MAINT_RESTRICT, 6'h0}; // R6
  localparam logic [31:0] ID4 = IMPL_WORD;                                // R7
  // Writable bits of control zero
  localparam logic [31:0] CTL_MASK =
    ({31'h0, STALLD_OK} << STALLD_BIT)                    // R9
    | ({29'h0, {3{WILD_SUPPORT}}} << WILD_LSB)
    | (32'h0000_0001 << FETCH_BIT);

  // ==========================================================
  // Control register state
  logic [31:0] ctl;      // Secure control zero
  logic [31:0] ack;      // Ack copy
  logic [31:0] next_ctl;
  logic [31:0] next_ack;
  logic        wr_ok;    // Accepted control write

  // Writes land only when gated in
  always_comb begin
    wr_ok    = req_i.valid && req_i.write && gate_ok(req_i)
               && hit(req_i.addr, OFF_CTL);                    // R21
    next_ctl = wr_ok ? (req_i.wdata & CTL_MASK) : ctl;         // R2 R21
    next_ack = ctl & CTL_MASK;                                 // R10 R22
  end

  // Both clear at reset
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctl <= CTL_RESET; // R20
      ack <= CTL_RESET;
    end else begin
      ctl <= next_ctl;
      ack <= next_ack;
    end
  end

  // ==========================================================
  // Read path, one cycle answer for reads and writes
  sidcr_rsp_t next_rsp;
  logic [31:0] rd;  // Selected word

  // Id words are never written; writes just answer
  always_comb begin
    rd = 32'h0;
    if (gate_ok(req_i)) begin // R2 R23
      if (hit(req_i.addr, OFF_ID1))      rd = ID1; // R1
      else if (hit(req_i.addr, OFF_ID2)) rd = ID2; // R4
      else if (hit(req_i.addr, OFF_ID3)) rd = ID3; // R6
      else if (hit(req_i.addr, OFF_ID4)) rd = ID4; // R7
      else if (hit(req_i.addr, OFF_CTL)) rd = ctl; // R21
      else if (hit(req_i.addr, OFF_ACK)) rd = ack; // R22
      else                               rd = 32'h0;
    end
    next_rsp.valid = req_i.valid;
    next_rsp.rdata = (req_i.valid && !req_i.write) ? rd : 32'h0;
  end

  // Answer register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o <= next_rsp;
    end
  end

  // ==========================================================
  // Derived status: stall model and query page
  logic [1:0]  next_model;
  logic [31:0] next_qoff;

  // Disable only counts when the secure side supports both models
  always_comb begin
    if (STALLD_OK && ctl[STALLD_BIT]) begin
      next_model = STALL_TERM; // R8
    end else begin
      next_model = SEC_STALL;  // R8 R9
    end
    next_qoff = PAGE_OFF + (32'(QUERY_BASE) * PAGE_STEP); // R4
  end

  // Status registers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ns_stall_model_o    <= STALL_BOTH;
      secure_query_page_o <= 1'b0;
      query_page_off_o    <= 32'h0;
    end else begin
      ns_stall_model_o    <= next_model;
      secure_query_page_o <= QPAGE;     // R5
      query_page_off_o    <= QPAGE ? next_qoff : 32'h0;
    end
  end

  // ==========================================================
  // Fetch guard check
  sidcr_fres_t next_fres;
  logic        trip;  // Guard condition met

  // Stage 1 decides only when it truly translates; events need a writable queue.
  // A cached guard value is software's problem to invalidate.  R19
  always_comb begin
    trip = fetch_i.valid && fetch_i.sec_stream && fetch_i.instr && fetch_i.s1_ns
           && ctl[FETCH_BIT] && SECURE_PRESENT;                          // R14
    next_fres        = '0;
    next_fres.valid  = fetch_i.valid;
    next_fres.fault  = trip;
    if (trip) begin
      if (!translation_unit_enable_i) begin
        next_fres.abort = 1'b1;                                         // R15
      end else if (!fetch_i.s1_applied) begin
        next_fres.abort  = 1'b1;                                        // R16
        next_fres.event_ = eventq_writable_i;                           // R16
      end else begin
        next_fres.stall  = fetch_i.ctx_s;                               // R17
        next_fres.abort  = !fetch_i.ctx_s && fetch_i.ctx_a;             // R17
        next_fres.event_ = eventq_writable_i && (fetch_i.ctx_s || fetch_i.ctx_r); // R17
      end
      next_fres.cls_in = next_fres.event_;                              // R18
      next_fres.s2     = 1'b0;                                          // R18
    end
  end

  // Result register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      fres_o <= '0;
    end else begin
      fres_o <= next_fres;
    end
  end

  // ==========================================================
  // Invalidation and lookup tag matching
  sidcr_tag_match #(
    .TAG_W(TAG_W)
  ) u_match (
    .ref_clk_i             (ref_clk_i),
    .rst_n_i               (rst_n_i),
    .wide_vm_tag_support_i (wide_vm_tag_support_i),
    .vm_tag_wildcard_i     (ctl[WILD_LSB +: WILD_W]), // R11 R13
    .inv_valid_i           (inv_valid_i),
    .inv_tag_i             (inv_tag_i),
    .lkp_valid_i           (lkp_valid_i),
    .lkp_tag_i             (lkp_tag_i),
    .entry_tag_i           (entry_tag_i),
    .inv_hit_o             (inv_hit_o),
    .lkp_hit_o             (lkp_hit_o)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_ns_read;
    req_i.valid && !req_i.write && !req_i.secure && !req_i.root;
  endsequence
  sequence s_ctl_write;
    wr_ok;
  endsequence

  a_raz_gate_read: assert property (s_ns_read |=> rsp_o.valid && rsp_o.rdata == 32'h0) // R2
    else $error("non-secure read saw data");
  a_wi_gate_write: assert property (req_i.valid && req_i.write && !req_i.secure // R21
    && !req_i.root |=> ctl == $past(ctl)) else $error("non-secure write landed");
  a_ack_follows_ctl: assert property (s_ctl_write ##1 1'b1 |=> ack == ($past(ctl) & CTL_MASK)) // R22
    else $error("ack did not follow control");
  a_ack_no_reserved: assert property ((ack & ~CTL_MASK) == 32'h0) // R10
    else $error("reserved bit in ack");
  a_stall_override: assert property (STALLD_OK && ctl[STALLD_BIT] |=> // R8
    ns_stall_model_o == STALL_TERM) else $error("stall disable ignored");
  a_stall_mirror: assert property (!ctl[STALLD_BIT] |=> ns_stall_model_o == SEC_STALL) // R9
    else $error("stall model not mirrored");
  a_fetch_unit_off: assert property (trip && !translation_unit_enable_i |=> // R15
    fres_o.abort && !fres_o.event_) else $error("disabled fetch fault wrong");
  a_fetch_bypass: assert property (trip && translation_unit_enable_i && !fetch_i.s1_applied // R16
    |=> fres_o.abort && fres_o.event_ == $past(eventq_writable_i))
    else $error("bypass fetch fault wrong");
  a_fetch_event_tag: assert property (fres_o.event_ |-> fres_o.cls_in && !fres_o.s2) // R18
    else $error("event fields wrong");
  a_guard_off_quiet: assert property (!ctl[FETCH_BIT] |=> !fres_o.fault) // R14
    else $error("fault with guard off");
  a_id_word_one: assert property (req_i.valid && !req_i.write && gate_ok(req_i) // R1
    && req_i.addr == OFF_ID1 |=> rsp_o.rdata[5:0] == SID_WIDTH)
    else $error("width field wrong");
endmodule : sidcr_regs

// ---- test/sidcr_host_model.sv ----
// Requester model that issues single register accesses to the bank
`timescale 1ns/1ns
module sidcr_host_model
  import sidcr_pkg::*;
(
  input  wire logic       ref_clk_i,
  output sidcr_req_t      req_o,
  input  wire sidcr_rsp_t rsp_i
);
  // ==========================================================
  // Idle bus: no strobe at time zero
  initial begin
    req_o = '0;
  end
  // One full-word access: strobe one cycle, then wait a bounded time
  task automatic access(input logic wr, input logic [15:0] addr, input logic [31:0] wdata,
                        input logic sec, input logic root, output logic [31:0] rdata);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    req_o = '{valid: 1'b1, write: wr, addr: addr, wdata: wdata, secure: sec, root: root};
    @(negedge ref_clk_i);
    // Released lines flip so stale values never pass for fresh ones
    req_o.valid = 1'b0;
    req_o.addr  = ~addr;
    req_o.wdata = ~wdata;
    while (rsp_i.valid !== 1'b1 && n < 4) begin
      @(negedge ref_clk_i);
      n++;
    end
    rdata = (n < 4) ? rsp_i.rdata : 32'hxxxx_xxxx; // Lost answer never matches
  endtask : access
endmodule : sidcr_host_model

// ---- test/tb_secure_iommu_id_and_control_regs.sv ----
// Self-checking bench for the secure id and control register bank
`timescale 1ns/1ns
module tb_secure_iommu_id_and_control_regs;
  import sidcr_pkg::*;
  // ==========================================================
  // Build choices and expectations
  localparam logic [5:0]  P_SIDW   = 6'h11;
  localparam logic [9:0]  P_QB     = 10'h003;
  localparam logic [31:0] P_IMPL   = 32'h5a3c_0f96; // Arbitrary value
  localparam logic [31:0] CTL_MASK = 32'h0000_03e0; // Disable, wildcard, guard
  localparam logic [31:0] ID_TAB [5] = '{{26'h0, P_SIDW}, {22'h0, P_QB}, 32'h0000_0040,
                                         P_IMPL, 32'h0000_0000};
  logic         ref_clk;     // Bench clock
  logic         rst_n;       // Synchronous reset
  sidcr_req_t   req;         // Register request
  sidcr_rsp_t   rsp;         // Register answer
  logic         unit_en;     // Secure unit enable
  logic         evq_wr;      // Event queue writable
  sidcr_fetch_t fetch;       // Fetch check request
  sidcr_fres_t  fres;        // Fetch check result
  logic         wide;        // Wide tag mode
  logic         inv_valid;   // Invalidation compare
  logic         lkp_valid;   // Lookup compare
  logic [15:0]  inv_tag;     // Invalidation tag
  logic [15:0]  lkp_tag;     // Lookup tag
  logic [15:0]  entry_tag;   // Stored tag
  logic         inv_hit;     // Invalidation hit
  logic         lkp_hit;     // Lookup hit
  logic [1:0]   ns_stall;    // Non-secure stall model
  logic         q_page;      // Query page present
  logic [31:0]  q_off;       // Query page offset
  sidcr_rsp_t   rsp_abs;     // Answer of the build without secure state
  logic         abs_page;    // Its query page flag
  logic [1:0]   abs_stall;   // Its non-secure stall model
  logic [31:0]  seed;        // Xorshift state
  int           num_errors;  // Mismatches
  int           comparisons; // Checks made
  // ==========================================================
  // Instances
  sidcr_regs #(.SID_WIDTH(P_SIDW), .QUERY_BASE(P_QB), .IMPL_WORD(P_IMPL),
               .MAINT_RESTRICT(1'b1)) i_dut (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .req_i(req), .rsp_o(rsp),
    .translation_unit_enable_i(unit_en), .eventq_writable_i(evq_wr),
    .fetch_i(fetch), .fres_o(fres), .wide_vm_tag_support_i(wide),
    .inv_valid_i(inv_valid), .inv_tag_i(inv_tag), .lkp_valid_i(lkp_valid),
    .lkp_tag_i(lkp_tag), .entry_tag_i(entry_tag), .inv_hit_o(inv_hit),
    .lkp_hit_o(lkp_hit), .ns_stall_model_o(ns_stall), .secure_query_page_o(q_page),
    .query_page_off_o(q_off));
  sidcr_host_model i_host (.ref_clk_i(ref_clk), .req_o(req), .rsp_i(rsp));
  // Second build without secure state and secure stall model code 2
  sidcr_regs #(.SECURE_PRESENT(1'b0), .SEC_STALL(2'h2)) i_dut_absent (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .req_i(req), .rsp_o(rsp_abs),
    .translation_unit_enable_i(unit_en), .eventq_writable_i(evq_wr),
    .fetch_i(fetch), .fres_o(), .wide_vm_tag_support_i(wide),
    .inv_valid_i(inv_valid), .inv_tag_i(inv_tag), .lkp_valid_i(lkp_valid),
    .lkp_tag_i(lkp_tag), .entry_tag_i(entry_tag), .inv_hit_o(), .lkp_hit_o(),
    .ns_stall_model_o(abs_stall), .secure_query_page_o(abs_page),
    .query_page_off_o());
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Tag match: wildcard drops low bits on invalidation only
  function automatic logic tag_exp(logic [15:0] a, logic [15:0] b, logic wd, int w, logic inv);
    logic [15:0] m;
    m = wd ? 16'hffff : 16'h00ff;
    if (inv && w >= 1 && w <= 4) begin
      m = m & (16'hffff << w);
    end
    return ((a ^ b) & m) == 16'h0000;
  endfunction : tag_exp
  // Fetch outcome: {valid, fault, abort, stall, event, class, stage two}
  function automatic logic [6:0] fetch_exp(sidcr_fetch_t f, logic g, logic en, logic wr);
    logic flt, ab, st, ev;
    flt = g & f.sec_stream & f.instr & f.s1_ns;
    ab  = 1'b0;
    st  = 1'b0;
    ev  = 1'b0;
    if (flt && !en) begin
      ab = 1'b1;
    end else if (flt && !f.s1_applied) begin
      ab = 1'b1;
      ev = wr;
    end else if (flt) begin
      st = f.ctx_s;
      ab = ~f.ctx_s & f.ctx_a;
      ev = wr & (f.ctx_s | f.ctx_r);
    end
    return {1'b1, flt, ab, st, ev, ev, 1'b0};
  endfunction : fetch_exp
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : chk
  task automatic results();
    $display("Checks made %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  // ==========================================================
  // Clock and watchdog; the run needs well under 2000 cycles
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    #(40 * 5000);
    num_errors++;
    results();
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] r, rd, wd, ctl;
    logic [15:0] addr;
    rst_n = 1'b0; unit_en = 1'b0; evq_wr = 1'b0; fetch = '0; wide = 1'b0;
    inv_valid = 1'b0; lkp_valid = 1'b0; inv_tag = '0; lkp_tag = '0; entry_tag = '0;
    seed = 32'h5e0e_9372; num_errors = 0; comparisons = 0; ctl = '0;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    // Reset state and static outputs
    i_host.access(1'b0, OFF_CTL, '0, 1'b1, 1'b0, rd);
    chk("control reset", 32'h0, rd);
    i_host.access(1'b0, OFF_ACK, '0, 1'b0, 1'b1, rd);
    chk("ack reset", 32'h0, rd);
    chk("stall model", {30'h0, STALL_BOTH}, {30'h0, ns_stall});
    chk("page offset", 32'h0005_0000, q_off);
    chk("page present", 32'h1, {31'h0, q_page});
    chk("absent page", 32'h0, {31'h0, abs_page});
    chk("mirror model", 32'h2, {30'h0, abs_stall});
    // Id words and an unmapped slot: secure, root, neither; writes never stick
    for (int a = 0; a < 3; a++) begin
      for (int k = 0; k < 5; k++) begin
        addr = (k == 4) ? 16'h8014 : OFF_ID1 + 16'(4 * k);
        i_host.access(1'b1, addr, xs(), a == 0, a == 1, rd);
        i_host.access(1'b0, addr, '0, a == 0, a == 1, rd);
        chk("id word", (a == 2) ? 32'h0 : ID_TAB[k], rd);
        chk("absent id word", 32'h0, rsp_abs.rdata);
      end
    end
    // Control writes under random attributes; ack and stall model follow
    for (int i = 0; i < 16; i++) begin
      r  = xs();
      wd = xs();
      i_host.access(1'b1, OFF_CTL, wd, r[0], r[1], rd);
      ctl = (r[0] | r[1]) ? (wd & CTL_MASK) : ctl;
      i_host.access(1'b0, OFF_CTL, '0, r[2], r[3], rd);
      chk("control", (r[2] | r[3]) ? ctl : 32'h0, rd);
      chk("absent control", 32'h0, rsp_abs.rdata);
      i_host.access(1'b0, OFF_ACK, '0, 1'b1, 1'b0, rd);
      chk("ack", ctl, rd);
      chk("stall model", {30'h0, ctl[9] ? STALL_TERM : STALL_BOTH}, {30'h0, ns_stall});
    end
    // Every wildcard code, with near-miss tags in both widths
    for (int w = 0; w < 8; w++) begin
      i_host.access(1'b1, OFF_CTL, 32'(w) << WILD_LSB, 1'b1, 1'b0, rd);
      for (int i = 0; i < 10; i++) begin
        r = xs();
        @(negedge ref_clk);
        wide = r[31]; inv_tag = r[15:0]; lkp_tag = r[15:0];
        entry_tag = r[15:0] ^ (r[16] ? 16'(r[20:17]) : (r[21] ? 16'h0100 : 16'h0000));
        inv_valid = 1'b1; lkp_valid = 1'b1;
        @(negedge ref_clk);
        inv_valid = 1'b0; lkp_valid = 1'b0;
        chk("inval hit", {31'h0, tag_exp(inv_tag, entry_tag, wide, w, 1'b1)}, {31'h0, inv_hit});
        chk("lookup hit", {31'h0, tag_exp(lkp_tag, entry_tag, wide, w, 1'b0)}, {31'h0, lkp_hit});
      end
    end
    // Fetch guard off then on, random stream and descriptor settings
    for (int g = 0; g < 2; g++) begin
      i_host.access(1'b1, OFF_CTL, 32'(g) << FETCH_BIT, 1'b1, 1'b0, rd);
      // Software flushes cached entries after a guard change
      @(negedge ref_clk);
      inv_tag = entry_tag; inv_valid = 1'b1;
      @(negedge ref_clk);
      inv_valid = 1'b0;
      chk("guard inval", 32'h1, {31'h0, inv_hit});
      for (int i = 0; i < 32; i++) begin
        r = xs();
        @(negedge ref_clk);
        unit_en = r[0] | r[1]; evq_wr = r[2];
        fetch = '{valid: 1'b1, sec_stream: r[3] | r[4], instr: r[5] | r[6], s1_ns: r[7] | r[8],
                  s1_applied: r[9], ctx_a: r[10], ctx_r: r[11], ctx_s: r[12]};
        @(negedge ref_clk);
        fetch.valid = 1'b0;
        wd = {25'h0, fetch_exp(fetch, g[0], unit_en, evq_wr)};
        chk("fetch", wd, {25'h0, fres.valid, fres.fault, fres.abort, fres.stall, fres.event_,
            fres.cls_in, fres.s2});
      end
    end
    results();
  end
endmodule : tb_secure_iommu_id_and_control_regs
